// ==== logic/nva_consts.svh ====
`ifndef NVA_CONSTS_SVH
`define NVA_CONSTS_SVH

// io register offsets
`define NVA_OFS_ADDR_HIGH   6'h1F
`define NVA_OFS_ADDR_LOW    6'h1E
`define NVA_OFS_DATA        6'h1D
`define NVA_OFS_CTRL        6'h1C

// control register fields
`define NVA_CTRL_ARM_BIT    2
`define NVA_CTRL_STROBE_BIT 1
`define NVA_CTRL_READ_BIT   0

// array geometry
`define NVA_DEPTH           512
`define NVA_ADDR_W          9

// timing
`define NVA_CLK_PERIOD_PS   5000
`define NVA_READ_STALL      3'h4
`define NVA_WRITE_STALL     3'h2
`define NVA_ARM_WINDOW      3'h4
`define NVA_OSC_PERIOD_PS   1000000
`define NVA_WRITE_OSC_CYC   8448
// divide first: the product in picoseconds would overflow a 32-bit int
`define NVA_CLK_PER_OSC     (`NVA_OSC_PERIOD_PS / `NVA_CLK_PERIOD_PS)
`define NVA_WRITE_CYCLES    (`NVA_WRITE_OSC_CYC * `NVA_CLK_PER_OSC)
`define NVA_BUSY_W          21

`endif

// ==== logic/nva_pkg.sv ====
package nva_pkg;
  typedef logic [8:0] nva_addr_t;
  typedef logic [7:0] nva_byte_t;
endpackage

// ==== logic/nva_store.sv ====
`timescale 1ns/1ps
`include "nva_consts.svh"

// byte array held in flip-flops; contents survive the port reset
module nva_store (
  input  wire logic              clk,
  input  wire logic              we,
  input  wire nva_pkg::nva_addr_t addr,
  input  wire nva_pkg::nva_byte_t wdata,
  output nva_pkg::nva_byte_t      rdata
);
  nva_pkg::nva_byte_t cells [`NVA_DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      cells[addr] <= wdata;
    end
  end

  assign rdata = cells[addr];
endmodule

// ==== logic/nva_port.sv ====
`timescale 1ns/1ps
`include "nva_consts.svh"

// What this block does
// - a separate 512-byte store, every byte readable and writable on its own
// - bytes addressed 0..511 by a 9-bit field split over two bytes
// - bits 15..9 of the high address byte always read zero
// - address undefined after reset; software writes it before any access
// - a read stalls the processor four clock cycles
// - a write stalls the processor two clock cycles
// - a write stores the data register byte at the selected address
// - a read loads the data register from the selected address
// - writes self-timed; the strobe bit shows when the next byte may go
// - address, data and control registers sit in the io space
// - writes start only after the arming sequence
// - arm bit self-clears after four cycles; strobe only acts while armed
// - strobe bit clears when the 8448-oscillator-cycle write time ends
// - read strobe completes at once; data register valid immediately
// - during a write, reads are ignored and the address cannot change
module nva_port #(
  parameter int WRITE_CYCLES = `NVA_WRITE_CYCLES
) (
  input  wire logic              clk,
  input  wire logic              rst_b,
  input  wire logic [5:0]        io_addr,
  input  wire logic              io_we,
  input  wire logic              io_re,
  input  wire nva_pkg::nva_byte_t io_wdata,
  output nva_pkg::nva_byte_t      io_rdata,
  output logic                    cpu_stall
);
  nva_pkg::nva_addr_t     nv_address_field;
  nva_pkg::nva_byte_t     nv_data;
  nva_pkg::nva_byte_t     mem_rdata;
  logic                   write_arm_bit;
  logic                   write_strobe_bit;
  logic [2:0]             arm_cnt;
  logic [2:0]             stall_cnt;
  logic [`NVA_BUSY_W-1:0] busy_cnt;
  logic                   ctrl_wr;
  logic                   arm_set;
  logic                   write_go;
  logic                   read_go;
  nva_pkg::nva_byte_t     next_rdata;

  // the cpu is halted while stalled, so nothing it presents then is taken
  function automatic logic io_hit(input logic en, input logic [5:0] a, input logic [5:0] ofs);
    io_hit = en && !cpu_stall && (a == ofs);
  endfunction

  assign ctrl_wr  = io_hit(io_we, io_addr, `NVA_OFS_CTRL);
  assign arm_set  = ctrl_wr && io_wdata[`NVA_CTRL_ARM_BIT];
  // strobe only acts on an arm bit already standing; arm and strobe in one write while unarmed is refused
  assign write_go = ctrl_wr && io_wdata[`NVA_CTRL_STROBE_BIT] && write_arm_bit && !write_strobe_bit;
  assign read_go  = ctrl_wr && io_wdata[`NVA_CTRL_READ_BIT] && !write_strobe_bit;

  nva_store u_store (
    .clk   (clk),
    .we    (write_go),
    .addr  (nv_address_field),
    .wdata (nv_data),
    .rdata (mem_rdata)
  );

  // address left unreset on purpose: its value after reset is undefined
  always_ff @(posedge clk) begin
    if (!write_strobe_bit) begin
      if (io_hit(io_we, io_addr, `NVA_OFS_ADDR_HIGH)) begin
        nv_address_field[8] <= io_wdata[0];
      end
      if (io_hit(io_we, io_addr, `NVA_OFS_ADDR_LOW)) begin
        nv_address_field[7:0] <= io_wdata;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (read_go) begin
      nv_data <= mem_rdata;
    end else if (io_hit(io_we, io_addr, `NVA_OFS_DATA)) begin
      nv_data <= io_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      arm_cnt <= 3'h0;
    end else if (arm_set) begin
      arm_cnt <= `NVA_ARM_WINDOW;
    end else if (arm_cnt != 3'h0) begin
      arm_cnt <= arm_cnt - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      write_arm_bit <= 1'b0;
    end else begin
      write_arm_bit <= arm_set || (arm_cnt > 3'h1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy_cnt         <= '0;
      write_strobe_bit <= 1'b0;
    end else if (write_go) begin
      busy_cnt         <= `NVA_BUSY_W'(WRITE_CYCLES - 1);
      write_strobe_bit <= 1'b1;
    end else if (busy_cnt != '0) begin
      busy_cnt <= busy_cnt - `NVA_BUSY_W'(1);
    end else begin
      write_strobe_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stall_cnt <= 3'h0;
    end else if (read_go) begin
      stall_cnt <= `NVA_READ_STALL - 3'h1;
    end else if (write_go) begin
      stall_cnt <= `NVA_WRITE_STALL - 3'h1;
    end else if (stall_cnt != 3'h0) begin
      stall_cnt <= stall_cnt - 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cpu_stall <= 1'b0;
    end else begin
      cpu_stall <= read_go || write_go || (stall_cnt != 3'h0);
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (io_addr)
      `NVA_OFS_ADDR_HIGH: next_rdata = {7'h00, nv_address_field[8]};
      `NVA_OFS_ADDR_LOW:  next_rdata = nv_address_field[7:0];
      `NVA_OFS_DATA:      next_rdata = nv_data;
      `NVA_OFS_CTRL:      next_rdata = {5'h00, write_arm_bit, write_strobe_bit, 1'b0};
      default:            next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      io_rdata <= 8'h00;
    end else if (io_re && !cpu_stall) begin
      io_rdata <= next_rdata;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_stall_n4;
    cpu_stall [*4] ##1 !cpu_stall;
  endsequence

  sequence s_stall_n2;
    cpu_stall [*2] ##1 !cpu_stall;
  endsequence

  logic hi_read_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hi_read_q <= 1'b0;
    end else begin
      hi_read_q <= io_re && !cpu_stall && (io_addr == `NVA_OFS_ADDR_HIGH);
    end
  end

  a_read_stall_len: assert property (read_go |=> s_stall_n4)
    else $error("read stall not four cycles");
  a_write_stall_len: assert property (write_go |=> s_stall_n2)
    else $error("write stall not two cycles");
  a_arm_holds: assert property (arm_set |=> write_arm_bit [*4])
    else $error("arm bit dropped early");
  a_arm_times_out: assert property ($fell(write_arm_bit) |-> $past(arm_set, 5))
    else $error("arm bit cleared at wrong time");
  a_strobe_needs_arm: assert property ($rose(write_strobe_bit) |-> $past(write_arm_bit))
    else $error("write started without arm");
  a_strobe_ends_timed: assert property ($fell(write_strobe_bit) |-> $past(busy_cnt) == '0 && $past(busy_cnt, 2) == 1)
    else $error("strobe cleared before write time");
  a_read_loads_data: assert property (read_go |=> nv_data == $past(mem_rdata))
    else $error("read did not load data register");
  a_busy_addr_hold: assert property (write_strobe_bit && $past(write_strobe_bit) |-> $stable(nv_address_field))
    else $error("address changed during write");
  a_busy_no_read: assert property (ctrl_wr && io_wdata[0] && write_strobe_bit |=> !cpu_stall)
    else $error("read accepted during write");
  a_resv_read_zero: assert property (hi_read_q |-> io_rdata[7:1] == 7'h00)
    else $error("reserved address bits read nonzero");

  // control reads: the read strobe is a command, not state, so it never reads back
  logic ctrl_read_q;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_read_q <= 1'b0;
    end else begin
      ctrl_read_q <= io_re && !cpu_stall && (io_addr == `NVA_OFS_CTRL);
    end
  end

  // independent age of the busy window, so the strobe length is not judged by busy_cnt alone
  logic [`NVA_BUSY_W-1:0] strobe_age;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      strobe_age <= '0;
    end else if (write_strobe_bit) begin
      strobe_age <= strobe_age + `NVA_BUSY_W'(1);
    end else begin
      strobe_age <= '0;
    end
  end

  // arm and strobe written together while unarmed must not start a write
  sequence s_arm_and_strobe_cold;
    ctrl_wr && io_wdata[`NVA_CTRL_ARM_BIT] && io_wdata[`NVA_CTRL_STROBE_BIT] && !write_arm_bit;
  endsequence

  sequence s_read_while_busy;
    ctrl_wr && io_wdata[`NVA_CTRL_READ_BIT] && write_strobe_bit;
  endsequence

  a_ctrl_read_bits: assert property (ctrl_read_q |-> io_rdata[7:3] == 5'h00 && io_rdata[0] == 1'b0)
    else $error("control register reserved bits read nonzero");
  a_strobe_length: assert property ($fell(write_strobe_bit) |-> $past(strobe_age) == `NVA_BUSY_W'(WRITE_CYCLES - 1))
    else $error("write busy window has wrong length");
  a_same_write_refused: assert property (s_arm_and_strobe_cold and !write_strobe_bit |=> !write_strobe_bit)
    else $error("arm and strobe in one write started programming");
  a_busy_data_kept: assert property (s_read_while_busy |=> $stable(nv_data))
    else $error("refused read changed the data register");
  a_stall_no_start: assert property (cpu_stall |-> !read_go && !write_go)
    else $error("access started while processor stalled");
  a_stall_has_cause: assert property ($rose(cpu_stall) |-> $past(read_go || write_go))
    else $error("stall raised without an access");
  a_write_lands: assert property (write_go |=> mem_rdata == $past(nv_data))
    else $error("write did not store the data register");
  a_rdata_holds: assert property (!$past(io_re && !cpu_stall) |-> $stable(io_rdata))
    else $error("read data changed without a read");
endmodule

// ==== dv/nva_port_tb_top.sv ====
`timescale 1ns/1ps
module nva_port_tb_top;
  logic               clk = 1'b0;
  logic               rst_b = 1'b0;
  logic [5:0]         io_addr = 6'h00;
  logic               io_we = 1'b0;
  logic               io_re = 1'b0;
  nva_pkg::nva_byte_t io_wdata = 8'h00;
  nva_pkg::nva_byte_t io_rdata;
  logic               cpu_stall;
  nva_pkg::nva_byte_t r;
  int                 n;
  int                 failures = 0;
  int                 total_checks = 0;

  always #2.5 clk = ~clk;

  // short write time keeps the run small; every busy window below assumes 30
  nva_port #(.WRITE_CYCLES(30)) dut (.clk(clk), .rst_b(rst_b), .io_addr(io_addr), .io_we(io_we),
    .io_re(io_re), .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_stall(cpu_stall));

  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // one idle cycle or more after each access, so io_we is never raised in the step it fell
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input int k);
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(negedge clk);
    // the stall launches at the edge that takes the write, so count from here
    n = int'(cpu_stall === 1'b1);
    io_we = 1'b0;
    repeat (k) begin
      @(negedge clk);
      n += int'(cpu_stall === 1'b1);
    end
  endtask

  task automatic rd(input logic [5:0] a);
    io_addr = a;
    io_re = 1'b1;
    @(negedge clk);
    io_re = 1'b0;
    r = io_rdata;
    @(negedge clk);
  endtask

  task automatic set_addr(input logic [8:0] a);
    wr(6'h1F, {7'h00, a[8]}, 1);
    wr(6'h1E, a[7:0], 1);
  endtask

  task automatic start_write(input logic [8:0] a, input logic [7:0] d);
    set_addr(a);
    wr(6'h1D, d, 1);
    wr(6'h1C, 8'h04, 1);
    wr(6'h1C, 8'h02, 6);
    chk(8'(n), 8'h02);
    rd(6'h1C);
    chk({7'h00, r[1]}, 8'h01);
  endtask

  task automatic poll_done();
    int i;
    for (i = 0; i < 40 && r[1] !== 1'b0; i++) rd(6'h1C);
    if (r[1] !== 1'b0) begin
      failures++;
      $display("[FAIL] %0t write never finished", $time);
      conclude();
    end
    chk(r, 8'h00);
  endtask

  task automatic nv_read(input logic [8:0] a, input logic [7:0] exp);
    set_addr(a);
    wr(6'h1C, 8'h01, 6);
    chk(8'(n), 8'h04);
    rd(6'h1D);
    chk(r, exp);
  endtask

  task automatic t_regs();
    wr(6'h1F, 8'hFF, 1);
    rd(6'h1F);
    chk(r, 8'h01);
    wr(6'h1E, 8'hA5, 1);
    rd(6'h1E);
    chk(r, 8'hA5);
    rd(6'h2A);
    chk(r, 8'h00);
    $display("test regs done");
  endtask

  // both ends of the range, 9'h000 and 9'h1FF, each written and then read back
  task automatic t_store();
    start_write(9'h000, 8'h3C);
    poll_done();
    start_write(9'h1FF, 8'hC3);
    poll_done();
    nv_read(9'h000, 8'h3C);
    nv_read(9'h1FF, 8'hC3);
    $display("test store done");
  endtask

  task automatic t_arm();
    wr(6'h1C, 8'h04, 1);
    rd(6'h1C);
    chk(r, 8'h04);
    repeat (4) @(negedge clk);
    rd(6'h1C);
    chk(r, 8'h00);
    wr(6'h1D, 8'h77, 1);
    wr(6'h1C, 8'h02, 6);
    chk(8'(n), 8'h00);
    wr(6'h1C, 8'h06, 6);
    chk(8'(n), 8'h00);
    nv_read(9'h1FF, 8'hC3);
    $display("test arm done");
  endtask

  task automatic t_busy();
    start_write(9'h005, 8'h5A);
    wr(6'h1E, 8'h11, 1);
    rd(6'h1E);
    chk(r, 8'h05);
    wr(6'h1C, 8'h01, 6);
    chk(8'(n), 8'h00);
    rd(6'h1D);
    chk(r, 8'h5A);
    rd(6'h1C);
    poll_done();
    nv_read(9'h005, 8'h5A);
    $display("test busy done");
  endtask

  // mid-run reset: control bits drop, store and address survive
  task automatic t_reset();
    start_write(9'h010, 8'h99);
    rst_b = 1'b0;
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk({7'h00, cpu_stall}, 8'h00);
    rd(6'h1C);
    chk(r, 8'h00);
    rd(6'h1E);
    chk(r, 8'h10);
    nv_read(9'h010, 8'h99);
    $display("test reset done");
  endtask

  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    chk({7'h00, cpu_stall}, 8'h00);
    t_regs();
    t_store();
    t_arm();
    t_busy();
    t_reset();
    conclude();
  end
endmodule
